// ### common/rst_defines.svh
// offsets, field positions, reset values and counts of the reset source controller
`ifndef RST_DEFINES_SVH
`define RST_DEFINES_SVH

// register byte offsets
`define REG_STATUS          8'h00
`define REG_CONTROL         8'h04
`define REG_HARD_CFG        8'h08
`define REG_SAMPLED_CFG     8'h0c
`define REG_SEQ_STATE       8'h10

// status bits: sources of the most recent resets
`define STAT_POR            0
`define STAT_HARD_EXT       1
`define STAT_WATCHDOG       2
`define STAT_BUS_MON        3
`define STAT_SOFT_EXT       4
`define STAT_TAP_HOST       5
`define STAT_W              6

// control bits
`define CTRL_WDT_EN         0
`define CTRL_BMON_EN        1
`define CTRL_EXTEST_SOFT    2
`define CTRL_CLAMP_SOFT     3
`define CTRL_HIGHZ_SOFT     4
`define CTRL_W              5
`define CTRL_RESET          5'h03
`define HARD_CFG_RESET      32'h0000_0000

// boundary-scan command codes
`define SCAN_NONE           2'h0
`define SCAN_EXTEST         2'h1
`define SCAN_CLAMP          2'h2
`define SCAN_HIGHZ          2'h3

// sampled configuration pin positions
`define CFG_RSTCONF_MODE    0
`define CFG_SLAVE_SEL       1
`define CFG_HOST_SYNC       2
`define CFG_HOST_64         3
`define CFG_CHIP_ID_LO      4
`define CFG_BOOT_LO         8
`define CFG_SWTE            11
`define CFG_CLOCK_MODE_SELECT_LO        12

// sequence lengths in input/reference clock cycles
`define POR_DELAY_CYCLES    11'd1024
`define HARD_RELEASE_CYCLES 11'd512
`define SOFT_RELEASE_CYCLES 11'd515
`define SYNC_BLANK_CYCLES   2'd3

`endif

// ### common/rst_pkg.sv
// types of the reset source controller
package rst_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_POR_HOLD,
    ST_POR_DELAY,
    ST_PLL_WAIT,
    ST_SEQ
  } reset_state_type;

  typedef enum logic [1:0] {
    KIND_POR,
    KIND_HARD,
    KIND_SOFT
  } reset_kind_type;

endpackage

// ### rtl/rst_sync.sv
// two-stage synchroniser for a reset pin level
`timescale 1ns/100ps
`default_nettype none

module rst_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // level
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_ff;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_ff <= RESET_VAL;
      q_out   <= RESET_VAL;
    end else begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end

endmodule // rst_sync

`default_nettype wire

// ### rtl/config_sampler.sv
// captures the configuration pins on a capture pulse
`timescale 1ns/100ps
`default_nettype none

module config_sampler #(
  parameter int CFG_W = 14
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // capture
  input  wire logic             capture_in,
  input  wire logic [CFG_W-1:0] pins_in,
  output logic      [CFG_W-1:0] cfg_out
);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_out <= '0;
    end else if (capture_in) begin
      cfg_out <= pins_in;
    end
  end

endmodule // config_sampler

`default_nettype wire

// ### rtl/reset_source_controller.sv
// reset source controller: sequencing, pin drive, config capture, status
//
// Notes on behaviour
// RQ1: board holds power-on reset input low at least 16 input clocks after supplies.
// RQ2: board keeps power-on and test logic reset asserted during power-up.
// RQ3: input clock toggles 16 cycles before power-on reset release.
// RQ4: power-on reset resets pll, cores, drives both pins, samples configuration.
// RQ5: clock mode, boot, chip id, port width latched only at power-on reset.
// RQ6: hard reset drives both pins, resets cores, applies 32-bit config word.
// RQ7: external soft reset seen only while device drives no reset.
// RQ8: soft reset drives soft pin, resets cores, keeps configuration.
// RQ9: enabled watchdog at zero starts a hard reset sequence.
// RQ10: enabled bus monitor at zero starts a hard reset sequence.
// RQ11: test port host reset command starts a soft reset sequence.
// RQ12: readable status shows sources of the most recent resets.
// RQ13: pin sampling, pll reset, host port config write: power-on only.
// RQ14: system bus config write, hard pin, interface regs: power-on and hard.
// RQ15: every source incl. scan commands resets peripherals, cores, shared bus.
// RQ16: power-on, hard, soft drive soft pin; scan commands per command.
// RQ17: power-on external only; hard external or internal; soft external or test.
// RQ18: clock minimum frequencies: input 20, reference 40, core 200 MHz.
// RQ19: pll input after predivider stays between 20 and 100 MHz.
// RQ20: pll oscillator output at least 800 MHz.
// RQ21: host port clock not above output clock, 70 or 100 MHz.
// RQ22: internal power-on reset released 1024 input clocks after pin release.
// RQ23: hard pin released 512 reference clocks after pll lock.
// RQ24: soft pin released 515 reference clocks after pll lock.
// RQ25: fourteen configuration pins captured at power-on reset release.
// RQ26: external hard and soft pins synchronised before use.
`timescale 1ns/100ps
`default_nettype none
`include "rst_defines.svh"

module reset_source_controller #(
  parameter int CFG_W = 14
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [31:0]      wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [31:0]      rdata_out,
  // reset pins
  input  wire logic             power_on_reset_n_in,
  input  wire logic             hard_reset_n_in,
  output logic                  hard_reset_n_out,
  output logic                  hard_reset_oe_out,
  input  wire logic             soft_reset_n_in,
  output logic                  soft_reset_n_out,
  output logic                  soft_reset_oe_out,
  // internal sources
  input  wire logic             watchdog_zero_in,
  input  wire logic             bus_monitor_zero_in,
  input  wire logic             tap_host_reset_in,
  input  wire logic [1:0]       scan_cmd_in,
  input  wire logic             system_pll_lock_in,
  input  wire logic [CFG_W-1:0] config_pins_in,
  // reset actions
  output logic                  system_pll_reset_out,
  output logic                  core_reset_out,
  output logic                  peripheral_bus_reset_out,
  output logic                  shared_bus_reset_out,
  output logic                  system_interface_unit_reset_out,
  output logic                  host_cfg_window_out,
  output logic                  sysbus_cfg_window_out,
  output logic      [31:0]      hard_cfg_word_out,
  output logic      [CFG_W-1:0] sampled_cfg_out
);

  rst_pkg::reset_state_type state_ff;
  rst_pkg::reset_state_type nxt_state;
  rst_pkg::reset_kind_type  kind_ff;
  rst_pkg::reset_kind_type  nxt_kind;
  logic [10:0]              cnt_ff;
  logic [10:0]              nxt_cnt;
  logic [1:0]               blank_ff;
  logic [`STAT_W-1:0]       status_ff;
  logic [`STAT_W-1:0]       set_bits;
  logic [`STAT_W-1:0]       clr_bits;
  logic [`CTRL_W-1:0]       ctrl_ff;
  logic [31:0]              hard_cfg_ff;
  logic [31:0]              rd_val;
  logic                     hard_sync;
  logic                     soft_sync;
  logic                     por_low;
  logic                     idle;
  logic                     in_seq;
  logic                     blank_done;
  logic                     scan_active;
  logic                     wdt_hit;
  logic                     bmon_hit;
  logic                     ext_hard_hit;
  logic                     ext_soft_hit;
  logic                     tap_hit;
  logic                     hard_go;
  logic                     soft_go;
  logic                     por_release;
  logic                     drive_hard_c;
  logic                     drive_soft_c;
  logic                     pll_reset_c;
  logic                     siu_reset_c;
  logic                     host_win_c;
  logic                     sys_win_c;
  logic                     early_seq;

  // soft pin drive for a boundary-scan command
  function automatic logic scan_soft(input logic [1:0] cmd, input logic [`CTRL_W-1:0] ctrl);
    logic r;
    r = 1'b0;
    if (cmd == `SCAN_EXTEST) begin
      r = ctrl[`CTRL_EXTEST_SOFT];
    end else if (cmd == `SCAN_CLAMP) begin
      r = ctrl[`CTRL_CLAMP_SOFT];
    end else if (cmd == `SCAN_HIGHZ) begin
      r = ctrl[`CTRL_HIGHZ_SOFT];
    end
    return r;
  endfunction

  // pin synchronisers
  rst_sync #(.RESET_VAL(1'b1)) u_hard_sync ( // [RQ26]
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (hard_reset_n_in),
    .q_out   (hard_sync)
  );

  rst_sync #(.RESET_VAL(1'b1)) u_soft_sync ( // [RQ26]
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    (soft_reset_n_in),
    .q_out   (soft_sync)
  );

  // strap capture on release of the power-on pin
  assign por_release = (state_ff == rst_pkg::ST_POR_HOLD) && power_on_reset_n_in; // [RQ25]

  config_sampler #(.CFG_W(CFG_W)) u_cfg (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .capture_in (por_release), // [RQ5] [RQ13]
    .pins_in    (config_pins_in),
    .cfg_out    (sampled_cfg_out)
  );

  // open-drain pins only ever pull low
  assign hard_reset_n_out = 1'b0;
  assign soft_reset_n_out = 1'b0;

  // source decode
  assign por_low      = !power_on_reset_n_in; // [RQ17]
  assign idle         = (state_ff == rst_pkg::ST_IDLE);
  assign in_seq       = (state_ff == rst_pkg::ST_SEQ);
  assign blank_done   = (blank_ff == `SYNC_BLANK_CYCLES);
  assign scan_active  = (scan_cmd_in != `SCAN_NONE);
  assign wdt_hit      = watchdog_zero_in && ctrl_ff[`CTRL_WDT_EN]; // [RQ9]
  assign bmon_hit     = bus_monitor_zero_in && ctrl_ff[`CTRL_BMON_EN]; // [RQ10]
  assign ext_hard_hit = !hard_sync && blank_done;
  assign ext_soft_hit = idle && blank_done && !soft_sync; // [RQ7]
  assign tap_hit      = idle && tap_host_reset_in; // [RQ11]
  // hard reset may also escalate a running soft sequence
  assign hard_go      = (idle || (in_seq && kind_ff == rst_pkg::KIND_SOFT))
                        && (ext_hard_hit || wdt_hit || bmon_hit); // [RQ17]
  assign soft_go      = !hard_go && (ext_soft_hit || tap_hit); // [RQ17]

  // reset actions per phase
  assign early_seq    = (state_ff == rst_pkg::ST_PLL_WAIT)
                        || (in_seq && cnt_ff < `HARD_RELEASE_CYCLES);
  assign pll_reset_c  = (state_ff == rst_pkg::ST_POR_HOLD)
                        || (state_ff == rst_pkg::ST_POR_DELAY); // [RQ4] [RQ13]
  assign drive_hard_c = (kind_ff != rst_pkg::KIND_SOFT) && !idle
                        && (pll_reset_c || early_seq); // [RQ6] [RQ14] [RQ23]
  assign drive_soft_c = !idle || (scan_active && scan_soft(scan_cmd_in, ctrl_ff)); // [RQ16] [RQ8]
  assign siu_reset_c  = !idle && (kind_ff != rst_pkg::KIND_SOFT); // [RQ14]
  assign host_win_c   = (kind_ff == rst_pkg::KIND_POR) && early_seq; // [RQ13]
  assign sys_win_c    = (kind_ff != rst_pkg::KIND_SOFT) && early_seq; // [RQ14]

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_kind  = kind_ff;
    nxt_cnt   = cnt_ff + 11'd1;
    if (por_low) begin
      nxt_state = rst_pkg::ST_POR_HOLD; // [RQ4]
      nxt_kind  = rst_pkg::KIND_POR;
      nxt_cnt   = 11'd0;
    end else if (hard_go) begin
      nxt_state = rst_pkg::ST_PLL_WAIT; // [RQ9] [RQ10]
      nxt_kind  = rst_pkg::KIND_HARD;
      nxt_cnt   = 11'd0;
    end else if (soft_go) begin
      nxt_state = rst_pkg::ST_SEQ; // [RQ11]
      nxt_kind  = rst_pkg::KIND_SOFT;
      nxt_cnt   = 11'd0;
    end else begin
      case (state_ff)
        rst_pkg::ST_POR_HOLD: begin
          nxt_state = rst_pkg::ST_POR_DELAY;
          nxt_cnt   = 11'd0;
        end
        rst_pkg::ST_POR_DELAY: begin
          if (cnt_ff == `POR_DELAY_CYCLES - 11'd1) begin
            nxt_state = rst_pkg::ST_PLL_WAIT; // [RQ22]
            nxt_cnt   = 11'd0;
          end
        end
        rst_pkg::ST_PLL_WAIT: begin
          // pll settles in range before lock [RQ18] [RQ19] [RQ20]
          nxt_cnt = 11'd0;
          if (system_pll_lock_in) begin
            nxt_state = rst_pkg::ST_SEQ;
          end
        end
        rst_pkg::ST_SEQ: begin
          if (cnt_ff == `SOFT_RELEASE_CYCLES - 11'd1) begin
            nxt_state = rst_pkg::ST_IDLE; // [RQ24]
            nxt_cnt   = 11'd0;
          end
        end
        default: begin
          nxt_cnt = 11'd0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= rst_pkg::ST_POR_HOLD;
      kind_ff  <= rst_pkg::KIND_POR;
      cnt_ff   <= 11'd0;
    end else begin
      state_ff <= nxt_state;
      kind_ff  <= nxt_kind;
      cnt_ff   <= nxt_cnt;
    end
  end

  // masks our own pin drive, sequence or scan, while it crosses the synchroniser
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      blank_ff <= 2'd0;
    end else if (!idle || soft_reset_oe_out) begin // [RQ7]
      blank_ff <= 2'd0;
    end else if (!blank_done) begin
      blank_ff <= blank_ff + 2'd1;
    end
  end

  // status: set wins over write-one-to-clear
  always_comb begin
    set_bits                 = '0;
    set_bits[`STAT_HARD_EXT] = hard_go && ext_hard_hit;
    set_bits[`STAT_WATCHDOG] = hard_go && wdt_hit;
    set_bits[`STAT_BUS_MON]  = hard_go && bmon_hit;
    set_bits[`STAT_SOFT_EXT] = soft_go && ext_soft_hit;
    set_bits[`STAT_TAP_HOST] = soft_go && tap_hit;
    clr_bits                 = '0;
    if (wr_in && addr_in == `REG_STATUS) begin
      clr_bits = wdata_in[`STAT_W-1:0];
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      status_ff <= `STAT_W'(1);
    end else if (por_low && state_ff != rst_pkg::ST_POR_HOLD) begin
      status_ff <= `STAT_W'(1); // [RQ12]
    end else begin
      status_ff <= (status_ff & ~clr_bits) | set_bits; // [RQ12]
    end
  end

  // interface-unit registers, reset to CTRL_RESET by power-on and hard reset
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (siu_reset_c) begin
      ctrl_ff <= `CTRL_RESET; // [RQ14]
    end else if (wr_in && addr_in == `REG_CONTROL) begin
      ctrl_ff <= wdata_in[`CTRL_W-1:0];
    end
  end

  // configuration word accepted only inside the write window
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hard_cfg_ff <= `HARD_CFG_RESET;
    end else if (wr_in && addr_in == `REG_HARD_CFG && sys_win_c) begin
      hard_cfg_ff <= wdata_in; // [RQ14]
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hard_cfg_word_out <= `HARD_CFG_RESET;
    end else if (in_seq && kind_ff != rst_pkg::KIND_SOFT
                 && cnt_ff == `HARD_RELEASE_CYCLES - 11'd1) begin
      hard_cfg_word_out <= hard_cfg_ff; // [RQ6] [RQ8]
    end
  end

  // register read
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_in == `REG_STATUS) begin
      rd_val[`STAT_W-1:0] = status_ff;
    end else if (addr_in == `REG_CONTROL) begin
      rd_val[`CTRL_W-1:0] = ctrl_ff;
    end else if (addr_in == `REG_HARD_CFG) begin
      rd_val = hard_cfg_ff;
    end else if (addr_in == `REG_SAMPLED_CFG) begin
      rd_val[CFG_W-1:0] = sampled_cfg_out;
    end else if (addr_in == `REG_SEQ_STATE) begin
      rd_val = {11'h000, cnt_ff, 5'h00, state_ff, kind_ff};
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= rd_in ? rd_val : 32'h0000_0000;
    end
  end

  // registered reset outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hard_reset_oe_out               <= 1'b1;
      soft_reset_oe_out               <= 1'b1;
      system_pll_reset_out            <= 1'b1;
      core_reset_out                  <= 1'b1;
      peripheral_bus_reset_out        <= 1'b1;
      shared_bus_reset_out            <= 1'b1;
      system_interface_unit_reset_out <= 1'b1;
      host_cfg_window_out             <= 1'b0;
      sysbus_cfg_window_out           <= 1'b0;
    end else begin
      hard_reset_oe_out               <= drive_hard_c;
      soft_reset_oe_out               <= drive_soft_c;
      system_pll_reset_out            <= pll_reset_c;
      core_reset_out                  <= !idle || scan_active; // [RQ15]
      peripheral_bus_reset_out        <= !idle || scan_active; // [RQ15]
      shared_bus_reset_out            <= !idle || scan_active; // [RQ15]
      system_interface_unit_reset_out <= siu_reset_c;
      host_cfg_window_out             <= host_win_c;
      sysbus_cfg_window_out           <= sys_win_c;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_por_drives_all: assert property ( // [RQ4]
    !power_on_reset_n_in |-> ##2 (hard_reset_oe_out && soft_reset_oe_out
                                  && core_reset_out && system_pll_reset_out))
    else $error("power-on reset did not drive all resets");
  a_por_delay_len: assert property ( // [RQ22]
    (state_ff == rst_pkg::ST_POR_DELAY && power_on_reset_n_in
     && cnt_ff < `POR_DELAY_CYCLES - 11'd1) |=> state_ff == rst_pkg::ST_POR_DELAY)
    else $error("internal power-on reset released early");
  a_hard_release: assert property ( // [RQ23]
    (in_seq && kind_ff != rst_pkg::KIND_SOFT && power_on_reset_n_in)
      |=> hard_reset_oe_out == ($past(cnt_ff) < `HARD_RELEASE_CYCLES))
    else $error("hard reset pin released at the wrong cycle");
  a_soft_release: assert property ( // [RQ24]
    (in_seq && cnt_ff == `SOFT_RELEASE_CYCLES - 11'd1 && power_on_reset_n_in
     && !scan_active) |=> ##1 !soft_reset_oe_out)
    else $error("soft reset pin not released after sequence");
  a_soft_only_idle: assert property ( // [RQ7]
    $rose(status_ff[`STAT_SOFT_EXT]) |-> $past(state_ff) == rst_pkg::ST_IDLE)
    else $error("external soft reset taken while driving reset");
  a_wdt_starts_hard: assert property ( // [RQ9]
    (wdt_hit && idle && power_on_reset_n_in)
      |=> (state_ff == rst_pkg::ST_PLL_WAIT && kind_ff == rst_pkg::KIND_HARD)
          ##1 hard_reset_oe_out)
    else $error("watchdog expiry did not start hard reset");
  a_bmon_status: assert property ( // [RQ10]
    (bmon_hit && idle && power_on_reset_n_in) |=> status_ff[`STAT_BUS_MON])
    else $error("bus monitor reset not recorded");
  a_tap_soft_seq: assert property ( // [RQ11]
    (tap_hit && power_on_reset_n_in && !hard_go)
      |=> kind_ff == rst_pkg::KIND_SOFT ##1 (soft_reset_oe_out && !hard_reset_oe_out))
    else $error("host reset command did not start soft reset");
  a_host_win_por: assert property ( // [RQ13]
    host_cfg_window_out |-> $past(kind_ff) == rst_pkg::KIND_POR)
    else $error("host port config window outside power-on reset");
  a_siu_not_soft: assert property ( // [RQ14]
    system_interface_unit_reset_out |-> $past(kind_ff) != rst_pkg::KIND_SOFT)
    else $error("interface registers reset by soft reset");
  a_scan_resets: assert property ( // [RQ15]
    scan_active |=> core_reset_out && peripheral_bus_reset_out && shared_bus_reset_out)
    else $error("scan command did not reset modules");
  a_cfg_capture: assert property ( // [RQ25]
    por_release |=> sampled_cfg_out == $past(config_pins_in))
    else $error("configuration pins not captured at release");
  a_cfg_stable: assert property ( // [RQ5]
    !por_release |=> $stable(sampled_cfg_out))
    else $error("configuration changed outside power-on reset");

endmodule // reset_source_controller

`default_nettype wire

// ### verification/board_model.sv
// board side model: power-on supervisor, pll lock source, open-drain pull-ups
`timescale 1ns/100ps
`default_nettype none

module board_model (
  // clock
  input  wire logic mclk_in,
  // requests from the bench
  input  wire logic por_req_in,
  input  wire logic pull_hard_in,
  input  wire logic pull_soft_in,
  // device pins
  input  wire logic hard_n_in,
  input  wire logic hard_oe_in,
  input  wire logic soft_n_in,
  input  wire logic soft_oe_in,
  output var logic  por_n_out,
  output var logic  lock_out,
  output logic      hard_wire_out,
  output logic      soft_wire_out
);
  int low_cnt  = 0;
  int lock_cnt = 0;

  initial begin
    por_n_out = 1'b0;
    lock_out  = 1'b0;
  end

  // pull-ups: wire low while any party pulls it
  assign hard_wire_out = !((hard_oe_in && !hard_n_in) || pull_hard_in);
  assign soft_wire_out = !((soft_oe_in && !soft_n_in) || pull_soft_in);

  always @(posedge mclk_in) begin
    low_cnt <= por_n_out ? 0 : low_cnt + 1;
    if (por_req_in)
      por_n_out <= 1'b0;
    else if (low_cnt >= 16)
      por_n_out <= 1'b1;
    lock_cnt <= por_n_out ? lock_cnt + 1 : 0;
    lock_out <= por_n_out && lock_cnt >= 200;
  end
endmodule // board_model
`default_nettype wire

// ### verification/reset_source_controller_tb.sv
// self-checking bench of the reset source controller
`timescale 1ns/100ps
`default_nettype none
`include "rst_defines.svh"

module reset_source_controller_tb;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        por_req = 1'b1;
  logic        pull_h = 1'b0;
  logic        pull_s = 1'b0;
  logic [2:0]  src = 3'h0;
  logic [1:0]  scan_cmd_in = 2'h0;
  logic [13:0] config_pins_in = 14'h0;
  logic [13:0] pins0, sampled_cfg_out;
  logic [31:0] rdata_out, hard_cfg_word_out, d, w;
  logic        power_on_reset_n_in, system_pll_lock_in, hard_reset_n_in, soft_reset_n_in;
  logic        hard_reset_n_out, hard_reset_oe_out, soft_reset_n_out, soft_reset_oe_out;
  logic        system_pll_reset_out, core_reset_out, peripheral_bus_reset_out;
  logic        shared_bus_reset_out, system_interface_unit_reset_out;
  logic        host_cfg_window_out, sysbus_cfg_window_out;
  logic [31:0] seed = 32'h132f1007;
  int          errors = 0, checks = 0, ncyc = 0, t0, t_pll, t_hard, t_soft, mstat = 1;
  bit          pp, ph, ps, pt, h_seen, hw_seen, sw_seen;

  always #50 mclk_in = ~mclk_in; // host port shares this one clock

  board_model bm_u (.mclk_in, .por_req_in(por_req), .pull_hard_in(pull_h),
    .pull_soft_in(pull_s), .hard_n_in(hard_reset_n_out), .hard_oe_in(hard_reset_oe_out),
    .soft_n_in(soft_reset_n_out), .soft_oe_in(soft_reset_oe_out),
    .por_n_out(power_on_reset_n_in), .lock_out(system_pll_lock_in),
    .hard_wire_out(hard_reset_n_in), .soft_wire_out(soft_reset_n_in));

  reset_source_controller dut_u (.mclk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .power_on_reset_n_in, .hard_reset_n_in, .hard_reset_n_out,
    .hard_reset_oe_out, .soft_reset_n_in, .soft_reset_n_out, .soft_reset_oe_out,
    .watchdog_zero_in(src[0]), .bus_monitor_zero_in(src[1]), .tap_host_reset_in(src[2]),
    .scan_cmd_in, .system_pll_lock_in, .config_pins_in, .system_pll_reset_out,
    .core_reset_out, .peripheral_bus_reset_out, .shared_bus_reset_out,
    .system_interface_unit_reset_out, .host_cfg_window_out, .sysbus_cfg_window_out,
    .hard_cfg_word_out, .sampled_cfg_out);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // event times of the sequence, in clock cycles, sampled at the falling edge
  always @(negedge mclk_in) begin
    ncyc++;
    if (|src || (power_on_reset_n_in && !pt)) t0 = ncyc;
    if (pp && !system_pll_reset_out) t_pll = ncyc;
    if (ph && !hard_reset_oe_out) t_hard = ncyc;
    if (ps && !soft_reset_oe_out) t_soft = ncyc;
    pt = power_on_reset_n_in;
    pp = system_pll_reset_out;
    ph = hard_reset_oe_out;
    ps = soft_reset_oe_out;
    h_seen |= hard_reset_oe_out;
    hw_seen |= host_cfg_window_out;
    sw_seen |= sysbus_cfg_window_out;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in) {addr_in, wdata_in, wr_in} <= {a, v, 1'b1};
    @(posedge mclk_in) wr_in <= 1'b0;
    if (a == `REG_STATUS) mstat &= ~v;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge mclk_in) rd_in <= 1'b0;
    @(negedge mclk_in) v = rdata_out;
  endtask

  task automatic pulse(input int k);
    {h_seen, hw_seen, sw_seen} = 3'h0;
    @(posedge mclk_in) src <= 3'h1 << k;
    @(posedge mclk_in) src <= 3'h0;
  endtask

  task automatic wait_end();
    repeat (4) @(negedge mclk_in);
    for (int i = 0; i < 3000 && core_reset_out; i++) @(negedge mclk_in);
    repeat (10) @(negedge mclk_in);
    check(core_reset_out, 1'b0);
  endtask

  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #2ms;
    errors++;
    wrap_up();
  end

  initial begin
    w = xs();
    config_pins_in = w[13:0];
    pins0 = w[13:0];
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in) por_req <= 1'b0;
    wait_end();
    config_pins_in <= ~pins0;
    check(t_pll - t0, 1026);
    check(t_hard - t0, 1539);
    check(t_soft - t0, 1542);
    check(sampled_cfg_out, pins0);
    rd(`REG_SAMPLED_CFG, d);
    check(d, {18'h0, pins0});
    check(hw_seen, 1'b1);
    rd(`REG_STATUS, d);
    check(d, mstat);
    rd(`REG_CONTROL, d);
    check(d, 32'h03);
    rd(8'h40, d);
    check(d, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(`REG_STATUS, 32'h3f);
      w = xs();
      pulse(k);
      for (int i = 0; i < 600 && !sysbus_cfg_window_out; i++) @(negedge mclk_in);
      check({core_reset_out, peripheral_bus_reset_out, shared_bus_reset_out,
             system_interface_unit_reset_out}, 4'hf);
      wr(`REG_HARD_CFG, w);
      wait_end();
      check(t_hard - t0, 515);
      check(t_soft - t0, 518);
      check(hard_cfg_word_out, w);
      check(sampled_cfg_out, pins0);
      check(hw_seen, 1'b0);
      mstat |= 4 << k;
      rd(`REG_STATUS, d);
      check(d, mstat);
    end
    wr(`REG_CONTROL, 32'h0);
    wr(`REG_STATUS, 32'h3f);
    pulse(0);
    pulse(1);
    repeat (6) @(negedge mclk_in);
    check(core_reset_out, 1'b0);
    wr(`REG_CONTROL, 32'h3);
    wr(`REG_HARD_CFG, ~w);
    rd(`REG_HARD_CFG, d);
    check(d, w);
    pulse(2);
    wait_end();
    check(t_soft - t0, 517);
    check({h_seen, sw_seen}, 2'h0);
    check(hard_cfg_word_out, w);
    for (int k = 0; k < 2; k++) begin
      wr(`REG_STATUS, 32'h3f);
      pulse(3);
      @(posedge mclk_in) {pull_h, pull_s} <= k ? 2'h1 : 2'h2;
      repeat (4) @(posedge mclk_in);
      {pull_h, pull_s} <= 2'h0;
      wait_end();
      check(h_seen, k == 0);
      mstat |= k ? 16 : 2;
      rd(`REG_STATUS, d);
      check(d, mstat);
    end
    wr(`REG_STATUS, 32'h3f);
    for (int c = 1; c < 4; c++)
      for (int e = 0; e < 2; e++) begin
        wr(`REG_CONTROL, 32'h3 | (e << (c + 1)));
        scan_cmd_in <= c[1:0];
        repeat (4) @(negedge mclk_in);
        check({soft_reset_oe_out, core_reset_out, peripheral_bus_reset_out,
               shared_bus_reset_out}, {e[0], 3'h7});
        @(posedge mclk_in) scan_cmd_in <= 2'h0;
        repeat (12) @(negedge mclk_in);
      end
    rd(`REG_STATUS, d);
    check(d, mstat);
    wrap_up();
  end
endmodule // reset_source_controller_tb
`default_nettype wire
